// ---- hdl/sfr_pkg.sv ----
// Constants for the serial-port enable, interrupt-enable and flag registers.
// Assumes an 8-bit register port with a small byte address space.
`default_nettype none
package sfr_pkg;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W = 3;
  localparam int          DATA_W = 8;
  localparam int          PORTS  = 2;
  localparam logic [2:0]  OFF_ME2 = 3'h0;
  localparam logic [2:0]  OFF_IE1 = 3'h1;
  localparam logic [2:0]  OFF_IE2 = 3'h2;
  localparam logic [2:0]  OFF_FL1 = 3'h3;
  localparam logic [2:0]  OFF_FL2 = 3'h4;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam logic [2:0]  P1_TX_BIT  = 3'h5;
  localparam logic [2:0]  P1_RX_BIT  = 3'h4;
  localparam logic [2:0]  P0S_TX_BIT = 3'h1;
  localparam logic [2:0]  P0S_RX_BIT = 3'h0;
  localparam logic [2:0]  P0F_TX_BIT = 3'h7;
  localparam logic [2:0]  P0F_RX_BIT = 3'h6;
  // ----------------------------------------------------------------
  // Reset values, one bit per port, and the reset value of the read-data byte
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_EN     = 2'h0;
  localparam logic [1:0]  RST_IE     = 2'h0;
  localparam logic [1:0]  RST_TX_FL  = 2'h3;
  localparam logic [1:0]  RST_RX_FL  = 2'h0;
  localparam logic [7:0]  RST_RDATA  = 8'h00;
endpackage
`default_nettype wire

// ---- hdl/usart_enable_irq_flag_regs.sv ----
// Enable, interrupt-enable and interrupt-flag bits of two serial ports.
// Assumes the ports report buffer events as one-cycle pulses on core_clk_i
// and a software reset bit as a level; all inputs are synchronous.
`default_nettype none
module usart_enable_irq_flag_regs
  import sfr_pkg::*;
#(
  parameter bit PLACE_SMALL = 1'b1
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [PORTS-1:0]  tx_buf_wr_i,
  input  wire logic [PORTS-1:0]  tx_buf_load_i,
  input  wire logic [PORTS-1:0]  rx_char_done_i,
  input  wire logic [PORTS-1:0]  rx_buf_rd_i,
  input  wire logic [PORTS-1:0]  software_reset_bit_i,
  output logic      [PORTS-1:0]  tx_enable_o,
  output logic      [PORTS-1:0]  rx_enable_o,
  output logic      [PORTS-1:0]  tx_irq_o,
  output logic      [PORTS-1:0]  rx_irq_o
);

  // ----------------------------------------------------------------
  // Placement helpers
  // ----------------------------------------------------------------
  // Enable bits of port0 always sit in the second enable register
  function automatic logic [2:0] en_pos(input logic p, input logic tx);
    en_pos = p ? (tx ? P1_TX_BIT : P1_RX_BIT) : (tx ? P0S_TX_BIT : P0S_RX_BIT);
  endfunction

  function automatic logic [2:0] irq_pos(input logic p, input logic tx);
    if (p || PLACE_SMALL) begin
      irq_pos = en_pos(p, tx);
    end else begin
      irq_pos = tx ? P0F_TX_BIT : P0F_RX_BIT;
    end
  endfunction

  function automatic logic in_second(input logic p);
    in_second = p || PLACE_SMALL;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PORTS-1:0]  en_tx_r, en_tx_nxt;
  logic [PORTS-1:0]  en_rx_r, en_rx_nxt;
  logic [PORTS-1:0]  ie_tx_r, ie_tx_nxt;
  logic [PORTS-1:0]  ie_rx_r, ie_rx_nxt;
  logic [PORTS-1:0]  fl_tx_r, fl_tx_nxt;
  logic [PORTS-1:0]  fl_rx_r, fl_rx_nxt;
  logic [PORTS-1:0]  irq_tx_r, irq_tx_nxt;
  logic [PORTS-1:0]  irq_rx_r, irq_rx_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Port0 irq-enable and flag bytes move with the placement
  function automatic logic [2:0] ie_off(input logic p);
    ie_off = in_second(p) ? OFF_IE2 : OFF_IE1;
  endfunction

  function automatic logic [2:0] fl_off(input logic p);
    fl_off = in_second(p) ? OFF_FL2 : OFF_FL1;
  endfunction

  logic              wr_en_hit;
  logic              rd_en_hit;
  logic [PORTS-1:0]  wr_ie_hit;
  logic [PORTS-1:0]  rd_ie_hit;
  logic [PORTS-1:0]  wr_fl_hit;
  logic [PORTS-1:0]  rd_fl_hit;

  always_comb begin
    wr_en_hit = wr_i && (addr_i == OFF_ME2);
    rd_en_hit = rd_i && (addr_i == OFF_ME2);
    wr_ie_hit = '0;
    rd_ie_hit = '0;
    wr_fl_hit = '0;
    rd_fl_hit = '0;
    for (int p = 0; p < PORTS; p++) begin
      wr_ie_hit[p] = wr_i && (addr_i == ie_off(1'(p)));
      rd_ie_hit[p] = rd_i && (addr_i == ie_off(1'(p)));
      wr_fl_hit[p] = wr_i && (addr_i == fl_off(1'(p)));
      rd_fl_hit[p] = rd_i && (addr_i == fl_off(1'(p)));
    end
  end

  // ----------------------------------------------------------------
  // Module enables
  // ----------------------------------------------------------------
  // only own bits are stored; other bits of the byte are dropped
  // A write replaces the enable bits of both ports at once
  always_comb begin
    en_tx_nxt = en_tx_r;
    en_rx_nxt = en_rx_r;
    for (int p = 0; p < PORTS; p++) begin
      if (wr_en_hit) begin
        en_tx_nxt[p] = wdata_i[en_pos(1'(p), 1'b1)];
        en_rx_nxt[p] = wdata_i[en_pos(1'(p), 1'b0)];
      end
    end
  end

  // Software reset of a port leaves its enables alone
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      en_tx_r <= RST_EN;
      en_rx_r <= RST_EN;
    end else begin
      en_tx_r <= en_tx_nxt;
      en_rx_r <= en_rx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------
  always_comb begin
    ie_tx_nxt = ie_tx_r;
    ie_rx_nxt = ie_rx_r;
    for (int p = 0; p < PORTS; p++) begin
      if (wr_ie_hit[p]) begin
        ie_tx_nxt[p] = wdata_i[irq_pos(1'(p), 1'b1)];
        ie_rx_nxt[p] = wdata_i[irq_pos(1'(p), 1'b0)];
      end
      if (software_reset_bit_i[p]) begin
        ie_tx_nxt[p] = 1'b0;
        ie_rx_nxt[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ie_tx_r <= RST_IE;
      ie_rx_r <= RST_IE;
    end else begin
      ie_tx_r <= ie_tx_nxt;
      ie_rx_r <= ie_rx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transmit flags
  // ----------------------------------------------------------------
  // Priority, lowest first: software write, buffer write, buffer empty,
  // software reset. An empty buffer in the cycle of a write wins, so a
  // pending transmit request is never lost.
  always_comb begin
    fl_tx_nxt = fl_tx_r;
    for (int p = 0; p < PORTS; p++) begin
      if (wr_fl_hit[p]) begin
        fl_tx_nxt[p] = wdata_i[irq_pos(1'(p), 1'b1)];
      end
      if (tx_buf_wr_i[p]) begin
        fl_tx_nxt[p] = 1'b0;
      end
      if (tx_buf_load_i[p]) begin
        fl_tx_nxt[p] = 1'b1;
      end
      if (software_reset_bit_i[p]) begin
        fl_tx_nxt[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fl_tx_r <= RST_TX_FL;
    end else begin
      fl_tx_r <= fl_tx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Receive flags
  // ----------------------------------------------------------------
  // Priority, lowest first: software write, buffer read, character
  // done, software reset.
  always_comb begin
    fl_rx_nxt = fl_rx_r;
    for (int p = 0; p < PORTS; p++) begin
      if (wr_fl_hit[p]) begin
        fl_rx_nxt[p] = wdata_i[irq_pos(1'(p), 1'b0)];
      end
      if (rx_buf_rd_i[p]) begin
        fl_rx_nxt[p] = 1'b0;
      end
      if (rx_char_done_i[p]) begin
        fl_rx_nxt[p] = 1'b1;
      end
      if (software_reset_bit_i[p]) begin
        fl_rx_nxt[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fl_rx_r <= RST_RX_FL;
    end else begin
      fl_rx_r <= fl_rx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // built from next values so a request never lags its flag
  // Requests are per port and direction; no global mask is kept here
  always_comb begin
    irq_tx_nxt = fl_tx_nxt & ie_tx_nxt;
    irq_rx_nxt = fl_rx_nxt & ie_rx_nxt;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_tx_r <= RST_IE;
      irq_rx_r <= RST_IE;
    end else begin
      irq_tx_r <= irq_tx_nxt;
      irq_rx_r <= irq_rx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data stands for one cycle only and is zero otherwise, so a
  // stale byte can never be mistaken for a fresh read.
  always_comb begin
    rdata_nxt = RST_RDATA;
    for (int p = 0; p < PORTS; p++) begin
      if (rd_en_hit) begin
        rdata_nxt[en_pos(1'(p), 1'b1)] = en_tx_r[p];
        rdata_nxt[en_pos(1'(p), 1'b0)] = en_rx_r[p];
      end
      if (rd_ie_hit[p]) begin
        rdata_nxt[irq_pos(1'(p), 1'b1)] = ie_tx_r[p];
        rdata_nxt[irq_pos(1'(p), 1'b0)] = ie_rx_r[p];
      end
      if (rd_fl_hit[p]) begin
        rdata_nxt[irq_pos(1'(p), 1'b1)] = fl_tx_r[p];
        rdata_nxt[irq_pos(1'(p), 1'b0)] = fl_rx_r[p];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_r <= RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o     = rdata_r;
  assign tx_enable_o = en_tx_r;
  assign rx_enable_o = en_rx_r;
  assign tx_irq_o    = irq_tx_r;
  assign rx_irq_o    = irq_rx_r;

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Random bench for the register bank against a bit-level model.
// Assumes the default small placement of the bank.
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: output mismatch", $time); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, exp_d;
  logic [1:0]  tw, tl, rc, rr, sw, txe, rxe, txq, rxq;
  logic [7:0]  m [0:7];
  logic [31:0] r;
  int          miscompares, total_checks, b;
  usart_enable_irq_flag_regs i_dut (.core_clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_buf_wr_i(tw),
    .tx_buf_load_i(tl), .rx_char_done_i(rc), .rx_buf_rd_i(rr), .software_reset_bit_i(sw),
    .tx_enable_o(txe), .rx_enable_o(rxe), .tx_irq_o(txq), .rx_irq_o(rxq));
  // ----------------
  // Model
  // ----------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ ({32{x[31]}} & 32'h0040_0007);
  endfunction
  task automatic step();
    exp_d = (rd && addr inside {3'h0, 3'h2, 3'h4}) ? m[addr] : 8'h00;
    if (rst) begin
      m = '{default: 8'h00};
      m[4] = 8'h22;
      exp_d = 8'h00;
    end else begin
      if (wr && addr inside {3'h0, 3'h2, 3'h4}) m[addr] = wdata & 8'h33;
      for (int p = 0; p < 2; p++) begin
        b = p ? 5 : 1;
        if (tw[p]) m[4][b] = 1'b0;
        if (rr[p]) m[4][b-1] = 1'b0;
        if (tl[p]) m[4][b] = 1'b1;
        if (rc[p]) m[4][b-1] = 1'b1;
        if (sw[p]) begin
          m[2][b] = 1'b0;
          m[2][b-1] = 1'b0;
          m[4][b-1] = 1'b0;
          m[4][b] = 1'b1;
        end
      end
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {wr, rd, addr, wdata, tw, tl, rc, rr, sw} = '0;
    rst = 1'b1;
    r = 32'h850e;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      step();
      r = lfsr(r);
      rst   <= i < 19 || r[31:25] == 7'h00;
      wr    <= r[1:0] == 2'h0;
      rd    <= r[1:0] == 2'h1;
      addr  <= r[4:2];
      wdata <= r[12:5];
      tw    <= r[14:13] & r[16:15];
      tl    <= r[18:17] & r[20:19];
      rc    <= r[22:21] & r[24:23];
      rr    <= r[26:25] & r[28:27];
      sw    <= {2{r[31:29] == 3'h7}} & r[14:13];
      #1;
      `CHK(rdata, exp_d)
      `CHK(txe, {m[0][5], m[0][1]})
      `CHK(rxe, {m[0][4], m[0][0]})
      `CHK(txq, {m[4][5] & m[2][5], m[4][1] & m[2][1]})
      `CHK(rxq, {m[4][4] & m[2][4], m[4][0] & m[2][0]})
    end
    stop_test();
  end
endmodule
`default_nettype wire

// ---- tb/usart_regs_checker.sv ----
// Assertions for the serial-port enable and flag register bank.
// Bound to the bank; sees its ports only.
`default_nettype none
module usart_regs_checker (
  input wire logic       core_clk_i, rst_i, wr_i, rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o,
  input wire logic [1:0] tx_buf_wr_i, tx_buf_load_i, rx_char_done_i, rx_buf_rd_i,
  input wire logic [1:0] software_reset_bit_i, tx_enable_o, rx_enable_o,
  input wire logic [1:0] tx_irq_o, rx_irq_o
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] txc;
  logic [1:0] rxc;
  assign txc = tx_buf_wr_i & ~tx_buf_load_i & ~software_reset_bit_i;
  assign rxc = rx_buf_rd_i & ~rx_char_done_i;
  a_tx_en_write: assert property (wr_i && addr_i == 3'h0 |=>
    tx_enable_o == {$past(wdata_i[5]), $past(wdata_i[1])}) else $error("tx enable lost");
  a_rx_en_write: assert property (wr_i && addr_i == 3'h0 |=>
    rx_enable_o == {$past(wdata_i[4]), $past(wdata_i[0])}) else $error("rx enable lost");
  a_en_hold: assert property (!(wr_i && addr_i == 3'h0) |=>
    $stable(tx_enable_o) && $stable(rx_enable_o)) else $error("enable moved");
  a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside slot");
  a_other_bits: assert property (rd_i |=> (rdata_o & 8'hCC) == 8'h00)
    else $error("foreign bits read");
  a_rx_clear: assert property (rxc != 2'h0 |=> (rx_irq_o & $past(rxc)) == 2'h0)
    else $error("rx irq after read");
  a_tx_clear: assert property (txc != 2'h0 |=> (tx_irq_o & $past(txc)) == 2'h0)
    else $error("tx irq after write");
  a_software_reset_bit_mask: assert property (software_reset_bit_i != 2'h0 |=>
    ((tx_irq_o | rx_irq_o) & $past(software_reset_bit_i)) == 2'h0) else $error("irq in software_reset_bit");
  a_irq_cause: assert property ($rose(rx_irq_o[1]) |->
    $past(rx_char_done_i[1]) || $past(wr_i)) else $error("rx irq without cause");
endmodule
bind usart_enable_irq_flag_regs usart_regs_checker i_chk (.*);
`default_nettype wire
